// ===== common/intr_dispatch_pkg.sv
// Purpose: constants for the interrupt and exception dispatch unit
// Assumes: priorities are 5 bits, vector offsets are byte offsets
// Notes: register numbers index an internal register space
package intr_dispatch_pkg;
  // internal register numbers
  localparam logic [7:0] REG_PRIORITY = 8'h12;
  localparam logic [7:0] REG_SW_POST = 8'h14;
  localparam logic [7:0] REG_SW_SUMMARY = 8'h15;
  // status word field
  localparam int PSW_PRI_LSB = 16;
  localparam int PSW_PRI_MSB = 20;
  // priority levels
  localparam logic [4:0] PRI_HALT = 5'h1f;
  localparam logic [4:0] PRI_POWER = 5'h1e;
  localparam logic [4:0] PRI_MEM_ERR = 5'h1d;
  localparam logic [4:0] PRI_CORR_ERR = 5'h1a;
  localparam logic [4:0] PRI_BUS_REQ = 5'h17;
  localparam logic [4:0] PRI_LEVEL6 = 5'h16;
  localparam logic [4:0] PRI_LEVEL5 = 5'h15;
  localparam logic [4:0] PRI_LEVEL4 = 5'h14;
  localparam logic [4:0] PRI_RESET = 5'h1f;
  // vector offsets
  localparam logic [11:0] VEC_POWER = 12'h00c;
  localparam logic [11:0] VEC_MEM_ERR = 12'h060;
  localparam logic [11:0] VEC_CORR_ERR = 12'h054;
  localparam logic [11:0] VEC_BUS_BASE = 12'h200;
  localparam logic [11:0] VEC_KSNV = 12'h008;
  localparam logic [11:0] VEC_SW_BASE = 12'h080;
  // halt codes
  localparam logic [3:0] HALT_EXTERNAL = 4'h2;
  localparam logic [3:0] HALT_RESET = 4'h3;
  // exception kinds
  localparam logic [1:0] EXC_TRAP = 2'h0;
  localparam logic [1:0] EXC_FAULT = 2'h1;
  localparam logic [1:0] EXC_ABORT = 2'h2;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_HALT = 4'b0010,
    ST_INTR = 4'b0100,
    ST_EXC = 4'b1000
  } disp_state_e;
endpackage

// ===== rtl/intr_exc_dispatch.sv
// Purpose: interrupt and exception dispatch of a diagnostic processor
// Assumes: event inputs are one-cycle pulses or levels, synchronous
// Notes: dispatch results other than o_dispatch, o_busy and o_priority are held until the next dispatch
//
// How it works
// RULE_01: halt saves state, priority 1f, firmware
// RULE_02: halts ignore priority, protected unless code 3
// RULE_03: maskable interrupt saves state, raises own priority
// RULE_04: bus request 4..7 sets priority 17
// RULE_05: power-up or dc cycle, bit clear: code 3
// RULE_06: dc cycle bit set, halt, break: code 2
// RULE_07: power-ok drop: priority 1e, vector 0c
// RULE_08: memory and bus errors: priority 1d, vector 60
// RULE_09: correctable memory error: priority 1a, vector 54
// RULE_10: bus vector plus 200
// RULE_11: summary holds pending levels 1 to 15
// RULE_12: posting writes pending at written level
// RULE_13: priority register loads status bits 20:16
// RULE_14: trap saves next instruction address
// RULE_15: fault saves faulting instruction address
// RULE_16: abort saves aborted instruction address
// RULE_17: exceptions keep priority, system failure 1f
// RULE_18: interrupt-stack-invalid or nested exceptions go firmware
// RULE_19: kernel stack invalid aborts via vector 08
// RULE_20: grant highest request above priority only
module intr_exc_dispatch (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // internal register access
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_num,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  // processor state
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_next_pc,
  input wire logic [31:0] i_status_word,
  input wire logic i_mapping_enable,
  input wire logic i_halt_protected,
  input wire logic i_system_control_bit7,
  // power sense and halt sources
  input wire logic i_bus_dc_ok,
  input wire logic i_bus_power_ok,
  input wire logic i_bus_halt_request,
  input wire logic i_console_break,
  // maskable sources
  input wire logic i_err_internal_parity,
  input wire logic i_err_bus_nonexistent_memory_wr,
  input wire logic i_err_dma_timeout,
  input wire logic i_err_nonexistent_memory,
  input wire logic i_err_mem_uncorr,
  input wire logic i_err_mem_corr,
  input wire logic [3:0] i_periph_req,
  input wire logic [11:0] i_periph_vec6,
  input wire logic [11:0] i_periph_vec4,
  input wire logic i_bus_request_level7,
  input wire logic i_bus_request_level6,
  input wire logic i_bus_request_level5,
  input wire logic i_bus_request_level4,
  input wire logic [11:0] i_bus_vector,
  // exceptions
  input wire logic i_exc_req,
  input wire logic [1:0] i_exc_kind,
  input wire logic [11:0] i_exc_vector,
  input wire logic i_exc_sys_fail,
  input wire logic i_exc_isnv,
  input wire logic i_exc_ksnv,
  input wire logic i_service_done,
  // dispatch results
  output logic o_dispatch,
  output logic o_to_firmware,
  output logic [11:0] o_vector,
  output logic [31:0] o_saved_pc,
  output logic [31:0] o_saved_status,
  output logic o_saved_mapping,
  output logic [3:0] o_halt_code,
  output logic [4:0] o_priority,
  output logic [1:0] o_exc_kind,
  output logic o_busy
);
  import intr_dispatch_pkg::*;

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  logic dc_ok_r;
  logic power_ok_r;
  logic was_off_r;
  logic was_off_nxt;
  logic dc_rise;
  logic power_drop;
  logic halt3_evt;
  logic halt2_evt;
  logic power_fail_r;
  logic power_fail_nxt;

  always_comb begin
    dc_rise = i_bus_dc_ok && !dc_ok_r;
    power_drop = power_ok_r && !i_bus_power_ok;
    was_off_nxt = was_off_r;
    if (!i_bus_dc_ok && !i_bus_power_ok) begin
      was_off_nxt = 1'b1;
    end else if (dc_rise) begin
      was_off_nxt = 1'b0;
    end
    // power-up sequence, or dc cycle with bit 7 clear
    halt3_evt = dc_rise && (was_off_r || !i_system_control_bit7); // [RULE_05]
    halt2_evt = (dc_rise && !was_off_r && i_system_control_bit7)
      || i_bus_halt_request || i_console_break; // [RULE_06]
  end

  // ---------------------------------------------------------------
  // request vector and arbitration
  // ---------------------------------------------------------------
  logic [15:0] sw_pending;
  logic [31:0] req_vec;
  logic grant;
  logic [4:0] grant_level;

  always_comb begin
    req_vec = {16'h0000, sw_pending};
    req_vec[PRI_POWER] = power_fail_r;
    req_vec[PRI_MEM_ERR] = i_err_internal_parity
      || i_err_bus_nonexistent_memory_wr || i_err_dma_timeout
      || i_err_nonexistent_memory || i_err_mem_uncorr; // [RULE_08]
    req_vec[PRI_CORR_ERR] = i_err_mem_corr; // [RULE_09]
    req_vec[PRI_BUS_REQ] = i_bus_request_level7;
    req_vec[PRI_LEVEL6] = i_bus_request_level6 || i_periph_req[3]
      || i_periph_req[2];
    req_vec[PRI_LEVEL5] = i_bus_request_level5;
    req_vec[PRI_LEVEL4] = i_bus_request_level4 || i_periph_req[1]
      || i_periph_req[0];
  end

  request_arbiter u_arb (
    .i_req(req_vec),
    .i_cur_pri(o_priority),
    .o_grant(grant),
    .o_level(grant_level)
  );

  // ---------------------------------------------------------------
  // dispatch state machine
  // ---------------------------------------------------------------
  disp_state_e state_r;
  disp_state_e state_nxt;
  logic dispatch_nxt;
  logic to_fw_nxt;
  logic [11:0] vector_nxt;
  logic [31:0] saved_pc_nxt;
  logic [31:0] saved_status_nxt;
  logic saved_map_nxt;
  logic [3:0] halt_code_nxt;
  logic [4:0] priority_nxt;
  logic [1:0] exc_kind_nxt;
  logic sw_clear;
  logic [4:0] bus_pri_level;

  function automatic logic [11:0] level_vector(input logic [4:0] lvl);
    logic [11:0] v;
    v = VEC_SW_BASE + {5'h00, lvl, 2'b00};
    return v;
  endfunction

  always_comb begin
    state_nxt = state_r;
    dispatch_nxt = 1'b0;
    to_fw_nxt = o_to_firmware;
    vector_nxt = o_vector;
    saved_pc_nxt = o_saved_pc;
    saved_status_nxt = o_saved_status;
    saved_map_nxt = o_saved_mapping;
    halt_code_nxt = o_halt_code;
    priority_nxt = o_priority;
    exc_kind_nxt = o_exc_kind;
    power_fail_nxt = power_fail_r || power_drop; // [RULE_07]
    sw_clear = 1'b0;
    bus_pri_level = grant_level;
    if (i_reg_wr && i_reg_num == REG_PRIORITY) begin
      priority_nxt = i_reg_wdata[4:0]; // [RULE_13]
    end
    case (state_r)
      ST_RUN, ST_INTR, ST_EXC, ST_HALT: begin
        if (i_service_done && state_r != ST_RUN) begin
          state_nxt = ST_RUN;
        end
        if (halt3_evt || (halt2_evt && !i_halt_protected)) begin // [RULE_02]
          state_nxt = ST_HALT;
          dispatch_nxt = 1'b1;
          to_fw_nxt = 1'b1; // [RULE_01]
          saved_pc_nxt = i_pc;
          saved_status_nxt = i_status_word;
          saved_map_nxt = i_mapping_enable;
          halt_code_nxt = halt3_evt ? HALT_RESET : HALT_EXTERNAL; // [RULE_05]
          priority_nxt = PRI_HALT; // [RULE_01]
        end else if (i_exc_req) begin
          state_nxt = ST_EXC;
          dispatch_nxt = 1'b1;
          exc_kind_nxt = i_exc_ksnv ? EXC_ABORT : i_exc_kind;
          saved_pc_nxt = (i_exc_kind == EXC_TRAP && !i_exc_ksnv)
            ? i_next_pc : i_pc; // [RULE_14] [RULE_15] [RULE_16]
          saved_status_nxt = i_status_word;
          to_fw_nxt = i_exc_isnv || state_r != ST_RUN; // [RULE_18]
          vector_nxt = i_exc_ksnv ? VEC_KSNV : i_exc_vector; // [RULE_19]
          if (i_exc_sys_fail || i_exc_ksnv || i_exc_isnv) begin
            priority_nxt = PRI_HALT; // [RULE_17]
          end
        end else if (grant && state_r == ST_RUN) begin
          state_nxt = ST_INTR;
          dispatch_nxt = 1'b1;
          to_fw_nxt = 1'b0;
          saved_pc_nxt = i_pc; // [RULE_03]
          saved_status_nxt = i_status_word;
          priority_nxt = grant_level; // [RULE_03]
          if (grant_level == PRI_POWER) begin
            vector_nxt = VEC_POWER; // [RULE_07]
            power_fail_nxt = power_drop;
          end else if (grant_level == PRI_MEM_ERR) begin
            vector_nxt = VEC_MEM_ERR; // [RULE_08]
          end else if (grant_level == PRI_CORR_ERR) begin
            vector_nxt = VEC_CORR_ERR; // [RULE_09]
          end else if (grant_level < PRI_LEVEL4) begin
            vector_nxt = level_vector(grant_level);
            sw_clear = 1'b1;
          end else if (grant_level == PRI_LEVEL6 && i_periph_req[3:2] != 2'h0
            && !i_bus_request_level6) begin
            vector_nxt = i_periph_vec6;
          end else if (grant_level == PRI_LEVEL4 && i_periph_req[1:0] != 2'h0
            && !i_bus_request_level4) begin
            vector_nxt = i_periph_vec4;
          end else begin
            vector_nxt = i_bus_vector + VEC_BUS_BASE; // [RULE_10]
            priority_nxt = PRI_BUS_REQ; // [RULE_04]
          end
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  sw_request_regs u_sw (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_post(i_reg_wr && i_reg_num == REG_SW_POST),
    .i_post_level(i_reg_wdata[3:0]),
    .i_load(i_reg_wr && i_reg_num == REG_SW_SUMMARY),
    .i_load_data(i_reg_wdata[15:0]),
    .i_clear(sw_clear),
    .i_clear_level(bus_pri_level[3:0]),
    .o_pending(sw_pending)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r <= ST_HALT;
      // no false dc edge right after reset; reset is the power-up halt
      dc_ok_r <= 1'b1;
      power_ok_r <= 1'b0;
      was_off_r <= 1'b0;
      power_fail_r <= 1'b0;
      o_dispatch <= 1'b1;
      o_to_firmware <= 1'b1;
      o_vector <= 12'h000;
      o_saved_pc <= 32'h0000_0000;
      o_saved_status <= 32'h0000_0000;
      o_saved_mapping <= 1'b0;
      o_halt_code <= HALT_RESET;
      o_priority <= PRI_RESET;
      o_exc_kind <= EXC_TRAP;
      o_busy <= 1'b1;
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      dc_ok_r <= i_bus_dc_ok;
      power_ok_r <= i_bus_power_ok;
      was_off_r <= was_off_nxt;
      power_fail_r <= power_fail_nxt;
      o_dispatch <= dispatch_nxt;
      o_to_firmware <= to_fw_nxt;
      o_vector <= vector_nxt;
      o_saved_pc <= saved_pc_nxt;
      o_saved_status <= saved_status_nxt;
      o_saved_mapping <= saved_map_nxt;
      o_halt_code <= halt_code_nxt;
      o_priority <= priority_nxt;
      o_exc_kind <= exc_kind_nxt;
      o_busy <= (state_nxt != ST_RUN);
      if (!i_reg_rd) begin
        o_reg_rdata <= 32'h0000_0000;
      end else if (i_reg_num == REG_PRIORITY) begin
        o_reg_rdata <= {27'h0, o_priority};
      end else if (i_reg_num == REG_SW_SUMMARY) begin
        o_reg_rdata <= {16'h0000, sw_pending};
      end else begin
        o_reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_halt_taken;
    o_dispatch && o_to_firmware && state_r == ST_HALT;
  endsequence

  property p_halt_pri;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_halt_taken |-> o_priority == PRI_HALT;
  endproperty
  a_halt_pri: assert property (p_halt_pri) // [RULE_01]
    else $error("halt did not set priority 1f");

  property p_code3;
    @(posedge i_clk_sys) disable iff (i_reset)
      halt3_evt |=> o_halt_code == HALT_RESET && state_r == ST_HALT;
  endproperty
  a_code3: assert property (p_code3) // [RULE_02]
    else $error("code 3 halt was blocked");

  property p_protected;
    @(posedge i_clk_sys) disable iff (i_reset)
      (halt2_evt && !halt3_evt && i_halt_protected && !i_exc_req
        && !(grant && state_r == ST_RUN)) |=> !o_dispatch;
  endproperty
  a_protected: assert property (p_protected) // [RULE_02]
    else $error("halt taken in protected space");

  property p_bus_pri;
    @(posedge i_clk_sys) disable iff (i_reset)
      (o_dispatch && state_r == ST_INTR && o_vector >= VEC_BUS_BASE)
        |-> o_priority == PRI_BUS_REQ;
  endproperty
  a_bus_pri: assert property (p_bus_pri) // [RULE_04]
    else $error("bus request did not set priority 17");

  property p_pri_write;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_reg_wr && i_reg_num == REG_PRIORITY && !halt3_evt && !halt2_evt
        && !i_exc_req && !(grant && state_r == ST_RUN))
        |=> o_priority == $past(i_reg_wdata[4:0]);
  endproperty
  a_pri_write: assert property (p_pri_write) // [RULE_13]
    else $error("priority write not loaded");

  property p_trap_pc;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_exc_req && i_exc_kind == EXC_TRAP && !i_exc_ksnv && !halt3_evt
        && !(halt2_evt && !i_halt_protected)) |=> o_saved_pc == $past(i_next_pc);
  endproperty
  a_trap_pc: assert property (p_trap_pc) // [RULE_14]
    else $error("trap saved wrong address");

  property p_ksnv;
    @(posedge i_clk_sys) disable iff (i_reset)
      (o_dispatch && state_r == ST_EXC && $past(i_exc_ksnv))
        |-> o_vector == VEC_KSNV && o_exc_kind == EXC_ABORT;
  endproperty
  a_ksnv: assert property (p_ksnv) // [RULE_19]
    else $error("kernel stack abort misdispatched");

  property p_grant_above;
    @(posedge i_clk_sys) disable iff (i_reset)
      (grant && state_r == ST_RUN && !halt3_evt && !halt2_evt && !i_exc_req)
        |=> o_priority > $past(o_priority);
  endproperty
  a_grant_above: assert property (p_grant_above) // [RULE_20]
    else $error("grant not above current priority");
endmodule

// ===== rtl/request_arbiter.sv
// Purpose: pick highest pending maskable request above current priority
// Assumes: request vector indexed by priority level
// Notes: unused levels are masked off
module request_arbiter (
  input wire logic [31:0] i_req,
  input wire logic [4:0] i_cur_pri,
  output logic o_grant,
  output logic [4:0] o_level
);
  import intr_dispatch_pkg::*;
  localparam logic [31:0] USED_LEVELS = 32'h64f0_fffe;

  always_comb begin
    o_grant = 1'b0;
    o_level = 5'h00;
    for (int i = 1; i < 32; i++) begin
      if (i_req[i] && USED_LEVELS[i] && 5'(i) > i_cur_pri) begin // [RULE_20]
        o_grant = 1'b1;
        o_level = 5'(i);
      end
    end
  end
endmodule

// ===== rtl/sw_request_regs.sv
// Purpose: software request pending flags, levels 1 to 15
// Assumes: one post and one clear per cycle at most
// Notes: a post wins over a clear of the same level
module sw_request_regs (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_post,
  input wire logic [3:0] i_post_level,
  input wire logic i_load,
  input wire logic [15:0] i_load_data,
  input wire logic i_clear,
  input wire logic [3:0] i_clear_level,
  output logic [15:0] o_pending
);
  import intr_dispatch_pkg::*;
  logic [15:0] pend_r;
  logic [15:0] pend_nxt;

  always_comb begin
    pend_nxt = pend_r;
    if (i_load) begin
      pend_nxt = i_load_data;
    end
    if (i_clear) begin
      pend_nxt[i_clear_level] = 1'b0;
    end
    if (i_post && i_post_level != 4'h0) begin
      pend_nxt[i_post_level] = 1'b1; // [RULE_12]
    end
    pend_nxt[0] = 1'b0; // [RULE_11]
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pend_r <= 16'h0000;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign o_pending = pend_r;

  property p_level0_clear;
    @(posedge i_clk_sys) disable iff (i_reset) pend_r[0] == 1'b0;
  endproperty
  a_level0_clear: assert property (p_level0_clear) // [RULE_11]
    else $error("level 0 pending flag set");

  property p_post_sets;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_post && i_post_level != 4'h0) |=> pend_r[$past(i_post_level)];
  endproperty
  a_post_sets: assert property (p_post_sets) // [RULE_12]
    else $error("posted software request not pending");
endmodule

// ===== test/bus_device_model.sv
// Purpose: backplane device that raises one request line and supplies a vector
// Assumes: started by the bench for one cycle, released on dispatch
// Notes: released vector lines show the inverse of the last value driven
module bus_device_model (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [1:0] i_level,
  input wire logic [11:0] i_vector,
  input wire logic i_dispatch,
  output logic [3:0] o_request,
  output logic [11:0] o_bus_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  // request bit 0 is level 4, bit 3 is level 7
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_request <= 4'h0;
      o_bus_vector <= 12'h000;
    end else if (i_start) begin
      o_request[i_level] <= 1'b1;
      o_bus_vector <= i_vector;
    end else if (i_dispatch && o_request != 4'h0) begin
      // device answered the grant: drop the line, vector no longer valid
      o_request <= 4'h0;
      o_bus_vector <= ~o_bus_vector;
    end
  end
endmodule

// ===== test/cpu_interrupt_exception_dispatch_tb_top.sv
// Purpose: self-checking bench of the interrupt and exception dispatch unit
// Assumes: inputs change at the falling edge, results read there too
// Notes: every dispatch but the correctable-error one ahead of the nested fault is followed by a service-done pulse
`define check_eq(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module cpu_interrupt_exception_dispatch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import intr_dispatch_pkg::*;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, map = 1, hprot = 0;
  logic bit7 = 0, dc_ok = 1, pw_ok = 1, halt_req = 0, brk = 0, corr = 0;
  logic start = 0, exc_req = 0, sys_fail = 0, isnv = 0, ksnv = 0;
  logic svc_done = 0, disp, to_fw, s_map, busy;
  logic [7:0] reg_num = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, s_pc, s_sw, exp_pc;
  logic [31:0] pc = 32'h0000_1000, next_pc = 32'h0000_1004;
  logic [31:0] sw = 32'h0004_00c4;
  logic [4:0] err = 5'h00, pri;
  logic [3:0] periph = 4'h0, breq, hcode;
  logic [1:0] lvl = 2'h0, ekind = 2'h0, o_kind;
  logic [11:0] mvec = 12'h000, bvec, vec, evec = 12'h034;
  int n_fail = 0, cmp_count = 0, cyc = 0;

  intr_exc_dispatch u_intr_exc_dispatch (
    .i_clk_sys(clk), .i_reset(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_num(reg_num), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_pc(pc), .i_next_pc(next_pc), .i_status_word(sw),
    .i_mapping_enable(map), .i_halt_protected(hprot),
    .i_system_control_bit7(bit7), .i_bus_dc_ok(dc_ok),
    .i_bus_power_ok(pw_ok), .i_bus_halt_request(halt_req),
    .i_console_break(brk), .i_err_internal_parity(err[0]),
    .i_err_bus_nonexistent_memory_wr(err[1]), .i_err_dma_timeout(err[2]),
    .i_err_nonexistent_memory(err[3]), .i_err_mem_uncorr(err[4]),
    .i_err_mem_corr(corr), .i_periph_req(periph),
    .i_periph_vec6(12'h0c0), .i_periph_vec4(12'h0f8),
    .i_bus_request_level7(breq[3]), .i_bus_request_level6(breq[2]),
    .i_bus_request_level5(breq[1]), .i_bus_request_level4(breq[0]),
    .i_bus_vector(bvec), .i_exc_req(exc_req), .i_exc_kind(ekind),
    .i_exc_vector(evec), .i_exc_sys_fail(sys_fail), .i_exc_isnv(isnv),
    .i_exc_ksnv(ksnv), .i_service_done(svc_done), .o_dispatch(disp),
    .o_to_firmware(to_fw), .o_vector(vec), .o_saved_pc(s_pc),
    .o_saved_status(s_sw), .o_saved_mapping(s_map), .o_halt_code(hcode),
    .o_priority(pri), .o_exc_kind(o_kind), .o_busy(busy));

  bus_device_model u_bus_device_model (
    .i_clk_sys(clk), .i_reset(rst), .i_start(start), .i_level(lvl),
    .i_vector(mvec), .i_dispatch(disp), .o_request(breq),
    .o_bus_vector(bvec));

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // access and dispatch helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] n, input logic [31:0] v);
    reg_num = n;
    wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] n, output logic [31:0] v);
    reg_num = n;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = rdata;
  endtask

  task automatic wait_disp();
    int k;
    k = 0;
    while (disp !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    `check_eq(disp, 1'b1)
  endtask

  task automatic no_disp();
    repeat (6) begin
      @(negedge clk);
      `check_eq(disp, 1'b0)
    end
  endtask

  task automatic serve();
    svc_done = 1'b1;
    @(negedge clk);
    svc_done = 1'b0;
    @(negedge clk);
    `check_eq(busy, 1'b0)
  endtask

  task automatic chk_int(input logic [4:0] p, input logic [11:0] v);
    `check_eq(to_fw, 1'b0)
    `check_eq(busy, 1'b1)
    `check_eq(pri, p)
    `check_eq(vec, v)
    `check_eq(s_pc, pc)
    `check_eq(s_sw, sw)
  endtask

  task automatic chk_halt(input logic [3:0] c);
    `check_eq(to_fw, 1'b1)
    `check_eq(busy, 1'b1)
    `check_eq(pri, PRI_HALT)
    `check_eq(hcode, c)
    `check_eq(s_map, 1'b1)
    `check_eq(s_sw, sw)
  endtask

  task automatic exc(input logic [1:0] k);
    ekind = k;
    exc_req = 1'b1;
    @(negedge clk);
    exc_req = 1'b0;
    wait_disp();
  endtask

  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    `check_eq(disp, 1'b1)
    `check_eq(to_fw, 1'b1)
    `check_eq(pri, PRI_HALT)
    `check_eq(hcode, HALT_RESET)
    serve();
    wr(REG_PRIORITY, 32'h5);
    rd(REG_PRIORITY, d);
    `check_eq(d[4:0], 5'h05)
    wr(REG_PRIORITY, 32'h1f);
    wr(REG_SW_POST, 32'h2);
    wr(REG_SW_POST, 32'h5);
    rd(REG_SW_SUMMARY, d);
    `check_eq(d[15:0], 16'h0024)
    wr(REG_PRIORITY, 32'h0);
    wait_disp();
    chk_int(5'h05, VEC_SW_BASE + 12'h014);
    serve();
    wr(REG_PRIORITY, 32'h0);
    wait_disp();
    chk_int(5'h02, VEC_SW_BASE + 12'h008);
    serve();
    for (int i = 0; i < 4; i++) begin
      wr(REG_PRIORITY, 32'h0);
      lvl = 2'(i);
      mvec = 12'h040 + 12'(i * 4);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      wait_disp();
      chk_int(PRI_BUS_REQ, mvec + VEC_BUS_BASE);
      serve();
    end
    wr(REG_PRIORITY, 32'h0);
    periph = 4'h4;
    wait_disp();
    chk_int(PRI_LEVEL6, 12'h0c0);
    periph = 4'h0;
    serve();
    wr(REG_PRIORITY, 32'h0);
    pw_ok = 1'b0;
    wait_disp();
    chk_int(PRI_POWER, VEC_POWER);
    pw_ok = 1'b1;
    serve();
    for (int i = 0; i < 5; i++) begin
      wr(REG_PRIORITY, 32'h0);
      err = 5'(1 << i);
      wait_disp();
      chk_int(PRI_MEM_ERR, VEC_MEM_ERR);
      err = 5'h00;
      serve();
    end
    wr(REG_PRIORITY, 32'h1a);
    corr = 1'b1;
    no_disp();
    wr(REG_PRIORITY, 32'h0);
    wait_disp();
    chk_int(PRI_CORR_ERR, VEC_CORR_ERR);
    corr = 1'b0;
    serve();
    hprot = 1'b1;
    halt_req = 1'b1;
    no_disp();
    hprot = 1'b0;
    wait_disp();
    chk_halt(HALT_EXTERNAL);
    `check_eq(s_pc, pc)
    halt_req = 1'b0;
    serve();
    brk = 1'b1;
    @(negedge clk);
    brk = 1'b0;
    wait_disp();
    chk_halt(HALT_EXTERNAL);
    serve();
    for (int i = 0; i < 2; i++) begin
      bit7 = (i == 0);
      hprot = (i == 1);
      dc_ok = 1'b0;
      @(negedge clk);
      dc_ok = 1'b1;
      wait_disp();
      chk_halt(bit7 ? HALT_EXTERNAL : HALT_RESET);
      serve();
    end
    hprot = 1'b0;
    bit7 = 1'b1;
    {dc_ok, pw_ok} = 2'b00;
    @(negedge clk);
    {dc_ok, pw_ok} = 2'b11;
    wait_disp();
    chk_halt(HALT_RESET);
    serve();
    wr(REG_PRIORITY, 32'h0);
    wait_disp();
    chk_int(PRI_POWER, VEC_POWER);
    serve();
    for (int k = 0; k < 3; k++) begin
      wr(REG_PRIORITY, 32'h4);
      exc(2'(k));
      exp_pc = (k == 0) ? next_pc : pc;
      `check_eq(s_pc, exp_pc)
      `check_eq(o_kind, 2'(k))
      `check_eq(pri, 5'h04)
      `check_eq(vec, evec)
      `check_eq(to_fw, 1'b0)
      serve();
    end
    sys_fail = 1'b1;
    exc(EXC_ABORT);
    `check_eq(pri, PRI_HALT)
    sys_fail = 1'b0;
    serve();
    ksnv = 1'b1;
    exc(EXC_ABORT);
    `check_eq(vec, VEC_KSNV)
    `check_eq(to_fw, 1'b0)
    ksnv = 1'b0;
    serve();
    isnv = 1'b1;
    exc(EXC_ABORT);
    `check_eq(to_fw, 1'b1)
    isnv = 1'b0;
    serve();
    wr(REG_PRIORITY, 32'h0);
    corr = 1'b1;
    wait_disp();
    corr = 1'b0;
    @(negedge clk);
    exc(EXC_FAULT);
    `check_eq(to_fw, 1'b1)
    serve();
    conclude();
  end
endmodule
